// ===== logic/slbc_top.sv
// self-test control of the serial link, deserializer side
// assumes all inputs synchronous to CLK_I; the back channel accepts one
// write per cycle while BC_READY_I is high
`timescale 1ns/100ps

module slbc_top (
    input  wire logic                            CLK_I,
    input  wire logic                            RST_B_I,
    input  wire logic                            SELFTEST_ENABLE_PIN_I,
    input  wire logic [1:0]                      GPIO_LVL_I,
    input  wire logic [7:0]                      REG_ADDR_I,
    input  wire logic                            REG_PORT_SEL_I,
    input  wire logic                            REG_WR_I,
    input  wire logic                            REG_RD_I,
    input  wire logic [7:0]                      REG_WDATA_I,
    output logic [7:0]                           REG_RDATA_O,
    output slbc_pkg::slbc_bc_wr_t                BC_WR_O,
    output logic                                 BC_VALID_O,
    input  wire logic                            BC_READY_I,
    input  wire slbc_pkg::slbc_rx_t [1:0]        RX_I,
    input  wire logic                            PGEN_ENABLE_I,
    output logic [1:0]                           LOCK_O,
    output logic [1:0]                           PASS_O,
    output logic                                 MONITOR_LOOP_O,
    output logic                                 VIDEO_OUT_EN_O,
    output logic                                 CSI_LP11_O,
    output logic                                 PGEN_DRIVE_O
);
    import slbc_pkg::*;

    // ==========================================================
    // control state
    slbc_state_t state_r, state_nxt;
    logic [7:0]  ctrl_r, ctrl_nxt;
    logic [1:0]  clksel_r, clksel_nxt;
    logic        pin_q_r, pin_q_nxt;
    logic        en_q_r, en_q_nxt;
    logic        bc_valid_r, bc_valid_nxt;
    slbc_bc_wr_t bc_wr_r, bc_wr_nxt;
    logic        start, run, want, start_pin, start_reg;
    logic [7:0]  tally_rd [NPORT];
    logic [NPORT-1:0] err;

    assign start_pin = SELFTEST_ENABLE_PIN_I & ~pin_q_r;
    assign start_reg = ctrl_r[CTRL_EN_BIT] & ~en_q_r;
    assign want      = SELFTEST_ENABLE_PIN_I | ctrl_r[CTRL_EN_BIT];
    assign run       = (state_r == ST_RUN);
    assign start     = (state_r == ST_IDLE) & (start_pin | start_reg);

    always_comb begin
        state_nxt    = state_r;
        clksel_nxt   = clksel_r;
        bc_valid_nxt = bc_valid_r;
        bc_wr_nxt    = bc_wr_r;
        pin_q_nxt    = SELFTEST_ENABLE_PIN_I;
        en_q_nxt     = ctrl_r[CTRL_EN_BIT];
        ctrl_nxt     = ctrl_r;
        if (REG_WR_I && REG_ADDR_I == ADDR_CTRL) begin
            ctrl_nxt = REG_WDATA_I & CTRL_WMASK;
        end
        unique case (state_r)
            ST_IDLE: begin
                if (start) begin
                    // pin start wins when both rise together
                    if (start_pin) begin
                        clksel_nxt = GPIO_LVL_I;
                    end else begin
                        clksel_nxt = ctrl_r[CTRL_CLK_LSB +: 2];
                    end
                    state_nxt         = ST_CFG;
                    bc_valid_nxt      = 1'b1;
                    bc_wr_nxt.port    = 1'b0;
                    bc_wr_nxt.addr    = SER_CLK_REG;
                    bc_wr_nxt.data    = SER_OFF;
                    bc_wr_nxt.data[SER_EN_BIT] = 1'b1;
                    bc_wr_nxt.data[SER_CLK_LSB +: 2] = clksel_nxt;
                end
            end
            ST_CFG, ST_STOP: begin
                // one write per serializer, port 0 first
                if (bc_valid_r && BC_READY_I) begin
                    if (bc_wr_r.port) begin
                        bc_valid_nxt = 1'b0;
                        state_nxt = (state_r == ST_CFG) ? ST_RUN : ST_IDLE;
                    end else begin
                        bc_wr_nxt.port = 1'b1;
                    end
                end
            end
            ST_RUN: begin
                // clock select is frozen for the whole run
                if (!want) begin
                    state_nxt      = ST_STOP;
                    bc_valid_nxt   = 1'b1;
                    bc_wr_nxt.port = 1'b0;
                    bc_wr_nxt.data = SER_OFF;
                end
            end
            default: begin
                state_nxt    = ST_IDLE;
                bc_valid_nxt = 1'b0;
            end
        endcase
    end

    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            state_r    <= ST_IDLE;
            ctrl_r     <= CTRL_RST;
            clksel_r   <= CLK_EXT;
            pin_q_r    <= 1'b0;
            en_q_r     <= 1'b0;
            bc_valid_r <= 1'b0;
            bc_wr_r    <= '0;
        end else begin
            state_r    <= state_nxt;
            ctrl_r     <= ctrl_nxt;
            clksel_r   <= clksel_nxt;
            pin_q_r    <= pin_q_nxt;
            en_q_r     <= en_q_nxt;
            bc_valid_r <= bc_valid_nxt;
            bc_wr_r    <= bc_wr_nxt;
        end
    end

    // ==========================================================
    // per-port pattern checker and error tally
    // parallel prbs7 generator, eight bits newest last in bit 0
    function automatic logic [14:0] prbs8(input logic [6:0] s);
        logic [6:0] st;
        logic [7:0] w;
        st = s;
        w  = 8'h00;
        for (int i = 7; i >= 0; i--) begin
            w[i] = st[6] ^ st[5];
            st   = {st[5:0], w[i]};
        end
        return {w, st};
    endfunction
    genvar g;
    generate
        for (g = 0; g < NPORT; g++) begin : g_port
            logic [6:0]  lfsr_r, lfsr_nxt;
            logic        sync_r, sync_nxt;
            logic        seen_r, seen_nxt;
            logic        lost_r, lost_nxt;
            logic [7:0]  tally_r, tally_nxt;
            logic [14:0] pred;
            assign pred = prbs8(lfsr_r);
            always_comb begin
                lfsr_nxt  = lfsr_r;
                sync_nxt  = sync_r;
                seen_nxt  = seen_r;
                lost_nxt  = lost_r;
                tally_nxt = tally_r;
                err[g]    = 1'b0;
                if (start) begin
                    lfsr_nxt  = PRBS_SEED;
                    sync_nxt  = 1'b0;
                    seen_nxt  = 1'b0;
                    lost_nxt  = 1'b0;
                    tally_nxt = TALLY_ZERO;
                end else if (run) begin
                    if (RX_I[g].lock) begin
                        seen_nxt = 1'b1;
                    end else begin
                        sync_nxt = 1'b0;
                        lost_nxt = lost_r | seen_r;
                    end
                    if (RX_I[g].lock && RX_I[g].valid) begin
                        // the stream seeds its own predictor
                        lfsr_nxt = RX_I[g].word[6:0];
                        sync_nxt = 1'b1;
                        if (sync_r && RX_I[g].word != pred[14:7]) begin
                            err[g] = 1'b1;
                            if (tally_r != TALLY_MAX) begin
                                tally_nxt = tally_r + 8'h01;
                            end
                        end
                    end
                end
            end
            always_ff @(posedge CLK_I or negedge RST_B_I) begin
                if (!RST_B_I) begin
                    lfsr_r  <= PRBS_SEED;
                    sync_r  <= 1'b0;
                    seen_r  <= 1'b0;
                    lost_r  <= 1'b0;
                    tally_r <= TALLY_ZERO;
                end else begin
                    lfsr_r  <= lfsr_nxt;
                    sync_r  <= sync_nxt;
                    seen_r  <= seen_nxt;
                    lost_r  <= lost_nxt;
                    tally_r <= tally_nxt;
                end
            end
            // before any lock the tally already reads as failed
            assign tally_rd[g] = (!seen_r || lost_r) ? TALLY_FAIL
                                                     : tally_r;
            property p_sat;
                @(posedge CLK_I) disable iff (!RST_B_I) tally_r != TALLY_FAIL;
            endproperty
            a_sat: assert property (p_sat)
                else $error("stored tally reached all ones");
            property p_lost;
                @(posedge CLK_I) disable iff (!RST_B_I)
                run && seen_r && !RX_I[g].lock |=> tally_rd[g] == TALLY_FAIL;
            endproperty
            a_lost: assert property (p_lost)
                else $error("lost lock does not read all ones");
            property p_clear;
                @(posedge CLK_I) disable iff (!RST_B_I)
                start |=> tally_r == TALLY_ZERO && !lost_r;
            endproperty
            a_clear: assert property (p_clear)
                else $error("tally not cleared at test start");
            property p_pass;
                @(posedge CLK_I) disable iff (!RST_B_I)
                err[g] |=> !PASS_O[g] ##1 PASS_O[g] == !$past(err[g]);
            endproperty
            a_pass: assert property (p_pass)
                else $error("pass not low for detected error");
        end
    endgenerate

    // ==========================================================
    // outputs, all registered
    logic [7:0] rdata_nxt;
    logic       out_en_nxt;

    always_comb begin
        rdata_nxt = REG_RDATA_O;
        if (REG_RD_I) begin
            unique case (REG_ADDR_I)
                ADDR_CTRL: begin
                    rdata_nxt = ctrl_r;
                    rdata_nxt[CTRL_ACT_BIT] = (state_r != ST_IDLE);
                end
                ADDR_ERR_TALLY: begin
                    rdata_nxt = tally_rd[REG_PORT_SEL_I];
                end
                default: begin
                    rdata_nxt = 8'h00;
                end
            endcase
        end
        out_en_nxt = (state_r == ST_IDLE) ||
                     (ctrl_r[CTRL_GATE_LSB +: 2] == GATE_ON);
    end

    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            REG_RDATA_O    <= 8'h00;
            LOCK_O         <= 2'b00;
            PASS_O         <= 2'b11;
            MONITOR_LOOP_O <= 1'b0;
            VIDEO_OUT_EN_O <= 1'b1;
            CSI_LP11_O     <= 1'b0;
            PGEN_DRIVE_O   <= 1'b0;
        end else begin
            REG_RDATA_O    <= rdata_nxt;
            LOCK_O         <= {RX_I[1].lock, RX_I[0].lock};
            PASS_O         <= ~err;
            MONITOR_LOOP_O <= RX_I[0].word[0];
            VIDEO_OUT_EN_O <= out_en_nxt;
            CSI_LP11_O     <= run && out_en_nxt && !PGEN_ENABLE_I;
            PGEN_DRIVE_O   <= run && out_en_nxt && PGEN_ENABLE_I;
        end
    end

    assign BC_WR_O    = bc_wr_r;
    assign BC_VALID_O = bc_valid_r;

    // ==========================================================
    // checks
    sequence s_start;
        state_r == ST_IDLE && start;
    endsequence
    sequence s_cfg_write;
        state_r == ST_CFG && BC_VALID_O && BC_WR_O.addr == SER_CLK_REG &&
        BC_WR_O.data[SER_EN_BIT];
    endsequence
    property p_start_cfg;
        @(posedge CLK_I) disable iff (!RST_B_I) s_start |=> s_cfg_write;
    endproperty
    a_start_cfg: assert property (p_start_cfg)
        else $error("start did not launch serializer write");

    property p_pin_clk;
        @(posedge CLK_I) disable iff (!RST_B_I)
        s_start ##0 start_pin |=> clksel_r == $past(GPIO_LVL_I) &&
        BC_WR_O.data[SER_CLK_LSB +: 2] == $past(GPIO_LVL_I);
    endproperty
    a_pin_clk: assert property (p_pin_clk)
        else $error("pin levels not copied to clock bits");

    property p_clk_hold;
        @(posedge CLK_I) disable iff (!RST_B_I)
        run ##1 run |-> $stable(clksel_r);
    endproperty
    a_clk_hold: assert property (p_clk_hold)
        else $error("clock select changed while running");

    property p_gate_off;
        @(posedge CLK_I) disable iff (!RST_B_I)
        run && ctrl_r[CTRL_GATE_LSB +: 2] == GATE_OFF
        |=> !VIDEO_OUT_EN_O && !CSI_LP11_O && !PGEN_DRIVE_O;
    endproperty
    a_gate_off: assert property (p_gate_off)
        else $error("outputs not gated off during test");

    property p_lp11;
        @(posedge CLK_I) disable iff (!RST_B_I)
        run && ctrl_r[CTRL_GATE_LSB +: 2] == GATE_ON && !PGEN_ENABLE_I
        |=> CSI_LP11_O && VIDEO_OUT_EN_O;
    endproperty
    a_lp11: assert property (p_lp11)
        else $error("csi-2 not idle in lp11");
endmodule

// ===== logic/slbc_pkg.sv
// constants, states and carriers of the serial link self-test control
// assumes one core clock and an 8-bit register port with per-port paging
package slbc_pkg;

    // ==========================================================
    // port count and register map
    localparam int         NPORT          = 2;
    localparam logic [7:0] ADDR_ERR_TALLY = 8'h57;
    localparam logic [7:0] ADDR_CTRL      = 8'hB3;

    // ==========================================================
    // control register fields
    localparam int         CTRL_EN_BIT    = 0;
    localparam int         CTRL_CLK_LSB   = 1;
    localparam int         CTRL_ACT_BIT   = 3;
    localparam int         CTRL_GATE_LSB  = 6;
    localparam logic [7:0] CTRL_RST       = 8'h00;
    localparam logic [7:0] CTRL_WMASK     = 8'hC7;
    localparam logic [1:0] GATE_OFF       = 2'b00;
    localparam logic [1:0] GATE_ON        = 2'b10;
    localparam logic [1:0] CLK_EXT        = 2'b00;

    // ==========================================================
    // remote serializer clock register
    localparam logic [7:0] SER_CLK_REG    = 8'h14;
    localparam int         SER_EN_BIT     = 0;
    localparam int         SER_CLK_LSB    = 1;
    localparam logic [7:0] SER_OFF        = 8'h00;

    // ==========================================================
    // error tally values and pattern checker
    localparam logic [7:0] TALLY_FAIL     = 8'hFF;
    localparam logic [7:0] TALLY_MAX      = 8'hFE;
    localparam logic [7:0] TALLY_ZERO     = 8'h00;
    localparam logic [6:0] PRBS_SEED      = 7'h7F;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_CFG  = 4'b0010,
        ST_RUN  = 4'b0100,
        ST_STOP = 4'b1000
    } slbc_state_t;

    typedef struct packed {
        logic       port;
        logic [7:0] addr;
        logic [7:0] data;
    } slbc_bc_wr_t;

    typedef struct packed {
        logic [7:0] word;
        logic       valid;
        logic       lock;
    } slbc_rx_t;

endpackage

// ===== verification/slbc_ser_model.sv
// ==========================================================
// remote serializer model: back-channel register sink and
// pseudo-random link stream source per receive port
// assumes the deserializer drives the back channel on CLK edges
`timescale 1ns/100ps

module slbc_ser_model
    import slbc_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_b_i,
    input  wire slbc_bc_wr_t bc_wr_i,
    input  wire logic        bc_valid_i,
    output logic             bc_ready_o,
    input  wire logic        slow_i,
    input  wire logic [1:0]  lock_en_i,
    input  wire logic        err_i,
    output slbc_rx_t [1:0]   rx_o,
    output logic [1:0][7:0]  ser_reg_o
);
    logic [6:0] st [2];

    // ==========================================================
    // prbs7 x^7+x^6+1, eight bits msb first
    function automatic logic [7:0] prbs(input logic [6:0] s);
        logic [7:0] w;
        logic       b;
        for (int i = 7; i >= 0; i--) begin
            b    = s[6] ^ s[5];
            s    = {s[5:0], b};
            w[i] = b;
        end
        return w;
    endfunction

    // ==========================================================
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            bc_ready_o <= 1'b0;
            ser_reg_o  <= '0;
            rx_o       <= '0;
            st[0]      <= PRBS_SEED;
            st[1]      <= PRBS_SEED;
        end else begin
            // slow mode stalls every other cycle
            bc_ready_o <= slow_i ? ~bc_ready_o : 1'b1;
            // frames taken as crc-clean; the model counts no errors
            if (bc_valid_i && bc_ready_o && bc_wr_i.addr == SER_CLK_REG) begin
                ser_reg_o[bc_wr_i.port] <= bc_wr_i.data;
            end
            for (int p = 0; p < 2; p++) begin
                if (ser_reg_o[p][SER_EN_BIT]) begin
                    // continuous stream; bit 7 flip keeps state intact
                    st[p]         <= 7'(prbs(st[p]));
                    rx_o[p].word  <= prbs(st[p]) ^ {err_i && p == 0, 7'h00};
                    rx_o[p].valid <= 1'b1;
                    rx_o[p].lock  <= lock_en_i[p];
                end else begin
                    // idle link shows a toggling word, never a held one
                    rx_o[p].word  <= ~rx_o[p].word;
                    rx_o[p].valid <= 1'b0;
                    rx_o[p].lock  <= 1'b0;
                end
            end
        end
    end
endmodule

// ===== verification/testbench.sv
// ==========================================================
// bench for the serial link self-test control
// assumes the strobe register port and the serializer model
`timescale 1ns/100ps

module testbench;
    import slbc_pkg::*;
    logic            clk, rst_b, pin, rd, wr, psel, pgen, slow, err;
    logic [1:0]      gpio, lock_en, lock, pass;
    logic [7:0]      addr, wdata, rdata, rv;
    logic [1:0][7:0] ser_reg;
    slbc_bc_wr_t     bc_wr;
    slbc_rx_t [1:0]  rx;
    logic            bc_valid, bc_ready, mon, ven, lp11, pdrv;
    int              bad_count = 0;
    int              n_compared = 0;
    int              k;

    slbc_top i_dut (
        .CLK_I(clk), .RST_B_I(rst_b), .SELFTEST_ENABLE_PIN_I(pin),
        .GPIO_LVL_I(gpio), .REG_ADDR_I(addr), .REG_PORT_SEL_I(psel),
        .REG_WR_I(wr), .REG_RD_I(rd), .REG_WDATA_I(wdata),
        .REG_RDATA_O(rdata), .BC_WR_O(bc_wr), .BC_VALID_O(bc_valid),
        .BC_READY_I(bc_ready), .RX_I(rx), .PGEN_ENABLE_I(pgen),
        .LOCK_O(lock), .PASS_O(pass), .MONITOR_LOOP_O(mon),
        .VIDEO_OUT_EN_O(ven), .CSI_LP11_O(lp11), .PGEN_DRIVE_O(pdrv)
    );

    slbc_ser_model i_ser (
        .clk_i(clk), .rst_b_i(rst_b), .bc_wr_i(bc_wr),
        .bc_valid_i(bc_valid), .bc_ready_o(bc_ready), .slow_i(slow),
        .lock_en_i(lock_en), .err_i(err), .rx_o(rx), .ser_reg_o(ser_reg)
    );

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // ==========================================================
    task automatic end_sim;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // tasks enter and leave at a falling edge
    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        addr  = a;
        wdata = d;
        wr    = 1'b1;
        @(negedge clk);
        wr    = 1'b0;
    endtask

    task automatic rreg(input logic [7:0] a, input logic p);
        addr = a;
        psel = p;
        rd   = 1'b1;
        @(negedge clk);
        rd   = 1'b0;
        rv   = rdata;
        @(negedge clk);
    endtask

    // bounded wait for both serializer clock registers to settle
    task automatic wait_ser(input logic [7:0] v);
        k = 0;
        while (!(ser_reg[0] === v && ser_reg[1] === v && bc_valid === 1'b0)
               && k < 50) begin
            @(negedge clk);
            k++;
        end
        chk(ser_reg[0], v);
        chk(ser_reg[1], v);
        repeat (2) @(negedge clk);
    endtask

    initial begin
        repeat (3000) @(posedge clk);
        bad_count++;
        $display("MISMATCH %0t watchdog expired", $time);
        end_sim;
    end

    // ==========================================================
    initial begin
        rst_b   = 1'b0;
        pin     = 1'b0;
        rd      = 1'b0;
        wr      = 1'b0;
        psel    = 1'b0;
        pgen    = 1'b0;
        slow    = 1'b0;
        err     = 1'b0;
        gpio    = 2'b00;
        lock_en = 2'b11;
        addr    = 8'h00;
        wdata   = 8'h00;
        repeat (3) @(negedge clk);
        rst_b = 1'b1;
        // test 1: reset state, unmapped address, read-only bits
        chk({6'h00, pass}, 8'h03);
        chk({7'h00, ven}, 8'h01);
        rreg(ADDR_CTRL, 1'b0);
        chk(rv, CTRL_RST);
        wreg(8'h10, 8'hFF);
        rreg(8'h10, 1'b0);
        chk(rv, 8'h00);
        wreg(ADDR_CTRL, 8'h38);
        rreg(ADDR_CTRL, 1'b0);
        chk(rv, 8'h00);
        $display("test 1 done");
        // test 2: register start, outputs on, errors counted
        wreg(ADDR_CTRL, 8'h85);
        wait_ser(8'h05);
        rreg(ADDR_CTRL, 1'b0);
        chk(rv, 8'h8D);
        wreg(ADDR_CTRL, 8'h83);
        repeat (4) @(negedge clk);
        chk(ser_reg[0], 8'h05);
        chk({5'h00, ven, lp11, pdrv}, 8'h06);
        pgen = 1'b1;
        repeat (2) @(negedge clk);
        chk({5'h00, ven, lp11, pdrv}, 8'h05);
        for (int i = 0; i < 8; i++) begin
            rv = {5'h00, rx[0].word[0], rx[1].lock, rx[0].lock};
            @(negedge clk);
            chk({5'h00, mon, lock}, rv);
        end
        rreg(ADDR_ERR_TALLY, 1'b0);
        chk(rv, TALLY_ZERO);
        k = 0;
        for (int i = 0; i < 12; i++) begin
            err = (i % 4 == 0);
            @(negedge clk);
            if (pass[0] === 1'b0) k++;
        end
        chk(8'(k), 8'h03);
        rreg(ADDR_ERR_TALLY, 1'b0);
        chk(rv, 8'h03);
        rreg(ADDR_ERR_TALLY, 1'b1);
        chk(rv, TALLY_ZERO);
        err = 1'b1;
        repeat (300) @(negedge clk);
        err = 1'b0;
        rreg(ADDR_ERR_TALLY, 1'b0);
        chk(rv, TALLY_MAX);
        wreg(ADDR_CTRL, 8'h00);
        wait_ser(SER_OFF);
        chk({7'h00, ven}, 8'h01);
        $display("test 2 done");
        // test 3: pin start with stalling back channel, lock faults
        // clock code 11 is avoided for parallel input serializers
        slow    = 1'b1;
        lock_en = 2'b01;
        gpio    = 2'b01;
        pin     = 1'b1;
        @(negedge clk);
        gpio = 2'b10;
        wait_ser(8'h03);
        chk({7'h00, ven}, 8'h00);
        repeat (10) @(negedge clk);
        chk({6'h00, lock}, 8'h01);
        rreg(ADDR_ERR_TALLY, 1'b1);
        chk(rv, TALLY_FAIL);
        rreg(ADDR_ERR_TALLY, 1'b0);
        chk(rv, TALLY_ZERO);
        lock_en = 2'b00;
        repeat (2) @(negedge clk);
        lock_en = 2'b01;
        repeat (4) @(negedge clk);
        rreg(ADDR_ERR_TALLY, 1'b0);
        chk(rv, TALLY_FAIL);
        pin = 1'b0;
        wait_ser(SER_OFF);
        $display("test 3 done");
        end_sim;
    end
endmodule
